/* File: hw/arop_params.svh */
// Constants of the converter result output port
`ifndef AROP_PARAMS_SVH
`define AROP_PARAMS_SVH
`define AROP_WIDTH          18
`define AROP_MODE_SERIAL    2'h3
`define AROP_CLK_MHZ        40
`define AROP_SCLK_AFTER_NS  100
`define AROP_SCLK_DURING_NS 200
`define AROP_QTR_AFTER      (((`AROP_SCLK_AFTER_NS * `AROP_CLK_MHZ) / 1000) / 4)
`define AROP_QTR_DURING     (((`AROP_SCLK_DURING_NS * `AROP_CLK_MHZ) / 1000) / 4)
`define AROP_BIT_SER_DATA   10
`define AROP_BIT_SCLK       11
`define AROP_BIT_SYNC       12
`define AROP_BIT_RDERR      13
`define AROP_OE_RESET       18'h3C000
`endif

/* File: hw/arop_pkg.sv */
// Types shared by the result output port
package arop_pkg;
   typedef struct packed {
      logic clk_src;
      logic clk_inv;
      logic sync_inv;
      logic rd_timing;
      logic fmt;
   } arop_ser_cfg_t;

   typedef struct packed {
      logic [17:0] dout;
      logic [17:0] oe;
   } arop_pins_t;

   typedef enum logic {ST_IDLE, ST_SHIFT} arop_state_t;
endpackage

/* File: hw/arop_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module arop_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_q[i]  <= 1'b1;
               s2_q[i]  <= 1'b1;
               s3_q[i]  <= 1'b1;
               level[i] <= 1'b1;
            end
            else
            begin
               s1_q[i] <= pin[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // Glitch of one sample is ignored
               if (s2_q[i] == s3_q[i])
                  level[i] <= s3_q[i];
            end
         end
      end
   endgenerate
endmodule

/* File: hw/arop_port.sv */
// Result output port: parallel bus or serial master/slave stream
// Functional notes
// R1 - Mode 3 gives pins serial roles, else parallel
// R2 - Read-after-convert: result out only after conversion
// R3 - Slave: chain input appears after 18 clocks
// R4 - Result latched in shift register, MSB first
// R5 - Offset binary or two's complement per select
// R6 - Master: bit stable across both clock edges
// R7 - Slave, no invert: update on rising edge
// R8 - Slave, invert: update on falling edge
// R9 - Clock pin direction and edge from selects
// R10 - Master sync normal: high during valid data
// R11 - Master sync inverted: low during valid data
// R12 - Slave incomplete read: drop data, pulse error
// R13 - Bits 14 to 17 always driven
// R14 - Busy from start until result latched
// R15 - Host may use busy fall as ready
// R16 - Read-during-convert: previous result, other period
// R17 - Slave: output follows external clock, chip-select gated
// R18 - Drivers on only with select and read low
// R19 - Host starts conversion with falling start edge
// R20 - One serial read is 18 clock periods
`timescale 1ns/1ps
`include "arop_params.svh"
module arop_port (
   input  wire logic                   clk_sys,
   input  wire logic                   arst_n,
   input  wire logic [1:0]             mode,
   input  wire arop_pkg::arop_ser_cfg_t cfg,
   input  wire logic                   cs_n,
   input  wire logic                   rd_n,
   input  wire logic                   conversion_start_n,
   input  wire logic                   sclk_in,
   input  wire logic                   chain_data_in,
   input  wire logic                   conv_done,
   input  wire logic [17:0]            conv_result,
   output arop_pkg::arop_pins_t        pins,
   output logic                        busy
);
   import arop_pkg::*;

   localparam logic [3:0] QTR_AFTER  = 4'(`AROP_QTR_AFTER);
   localparam logic [3:0] QTR_DURING = 4'(`AROP_QTR_DURING);

   logic [1:0]  rst_q;
   logic        rst_n;
   logic [4:0]  lvl;
   logic        cs_s, rd_s, cnv_s, sclk_s, chain_s;
   logic        cnv_prev_q, sclk_prev_q;
   logic        en, serial, master, slave, start_fall, upd_edge;
   logic        in_prog, err_cond, start_m, qtick;
   logic [17:0] result_q, shreg_q;
   logic [4:0]  cnt_q;
   logic [3:0]  div_q;
   logic [1:0]  qtr_q;
   logic        fast_q, err_q;
   arop_state_t st_q;
   arop_pins_t  pins_d;

   // ****************************************
   // Reset release and pin synchronisers
   // ****************************************
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   arop_sync #(.W(5)) u_sync (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .pin     ({cs_n, rd_n, conversion_start_n, sclk_in, chain_data_in}),
      .level   (lvl)
   );
   assign {cs_s, rd_s, cnv_s, sclk_s, chain_s} = lvl;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnv_prev_q  <= 1'b1;
         // Matches the synchroniser's reset level, so no false edge
         sclk_prev_q <= 1'b1;
      end
      else
      begin
         cnv_prev_q  <= cnv_s;
         sclk_prev_q <= sclk_s;
      end
   end

   assign en         = !cs_s && !rd_s;                                  // R18
   assign serial     = (mode == `AROP_MODE_SERIAL);                     // R1
   assign master     = serial && !cfg.clk_src;                          // R9
   assign slave      = serial && cfg.clk_src;
   assign start_fall = cnv_prev_q && !cnv_s;                            // R19
   // Edge choice follows the inversion select
   assign upd_edge   = slave && !cs_s && (cfg.clk_inv ? (sclk_prev_q && !sclk_s)   // R8 R17
                                                      : (!sclk_prev_q && sclk_s)); // R7 R17
   assign in_prog    = slave && (cnt_q != 5'h00) && (cnt_q < 5'(`AROP_WIDTH));
   assign err_cond   = conv_done && in_prog;                            // R12
   assign start_m    = master && en && (st_q == ST_IDLE)
                       && (cfg.rd_timing ? start_fall : conv_done);     // R2 R16
   assign qtick      = (div_q == ((fast_q ? QTR_DURING : QTR_AFTER) - 4'h1));

   // ****************************************
   // Busy and result latch
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         busy <= 1'b0;
      else if (conv_done)
         busy <= 1'b0;                                                  // R14
      else if (start_fall)
         busy <= 1'b1;                                                  // R14
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         result_q <= 18'h00000;
      else if (conv_done && !err_cond)
         result_q <= {conv_result[17] ^ cfg.fmt, conv_result[16:0]};    // R5
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         err_q <= 1'b0;
      else
         err_q <= err_cond;                                             // R12
   end

   // ****************************************
   // Shift register and frame sequencer
   // ****************************************
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         shreg_q <= 18'h00000;
      else if (conv_done && !err_cond && !(st_q == ST_SHIFT))
         shreg_q <= {conv_result[17] ^ cfg.fmt, conv_result[16:0]};     // R4
      else if (start_m)
         // A finished frame leaves the register empty: reload the held result
         shreg_q <= result_q;                                           // R16
      else if (master && st_q == ST_SHIFT && qtick && qtr_q == 2'h3)
         shreg_q <= {shreg_q[16:0], 1'b0};                              // R4 R6
      else if (upd_edge && cnt_q != 5'h00)
         shreg_q <= {shreg_q[16:0], chain_s};                           // R3
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q   <= ST_IDLE;
         div_q  <= 4'h0;
         qtr_q  <= 2'h0;
         fast_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               div_q <= 4'h0;
               qtr_q <= 2'h0;
               if (start_m)
               begin
                  st_q   <= ST_SHIFT;
                  fast_q <= cfg.rd_timing;                              // R16
               end
            end
            ST_SHIFT:
            begin
               div_q <= qtick ? 4'h0 : div_q + 4'h1;
               if (qtick)
                  qtr_q <= qtr_q + 2'h1;
               if (!master || (qtick && qtr_q == 2'h3 && cnt_q == 5'(`AROP_WIDTH - 1)))
                  st_q <= ST_IDLE;                                      // R20
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= 5'h00;
      else if (start_m || (slave && (cs_s || conv_done)))
         cnt_q <= 5'h00;
      else if (master && st_q == ST_SHIFT && qtick && qtr_q == 2'h3)
         cnt_q <= cnt_q + 5'h01;                                        // R20
      else if (upd_edge && cnt_q != 5'h1F)
         cnt_q <= cnt_q + 5'h01;                                        // R3
   end

   // ****************************************
   // Pin drivers
   // ****************************************
   always_comb
   begin
      pins_d.dout = result_q;                                           // R1
      pins_d.oe   = {4'hF, {14{en}}};                                   // R13 R18
      if (serial)
      begin
         pins_d.dout[9:0]             = 10'h000;
         pins_d.dout[`AROP_BIT_SER_DATA] = shreg_q[17];                 // R4
         // Clock active in quarters 1 and 2 (high, or low when inverted) keeps data clear of both edges
         pins_d.dout[`AROP_BIT_SCLK]  = ((st_q == ST_SHIFT) && (qtr_q == 2'h1 || qtr_q == 2'h2))
                                        ^ cfg.clk_inv;                  // R6 R9
         pins_d.dout[`AROP_BIT_SYNC]  = (master && st_q == ST_SHIFT) ^ cfg.sync_inv; // R10 R11
         pins_d.dout[`AROP_BIT_RDERR] = err_q;                          // R12
         pins_d.oe[9:0]               = 10'h000;
         pins_d.oe[`AROP_BIT_SCLK]    = en && master;                   // R9
         pins_d.oe[`AROP_BIT_SYNC]    = en && master;
         pins_d.oe[`AROP_BIT_RDERR]   = en && slave;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins.dout <= 18'h00000;
         pins.oe   <= `AROP_OE_RESET;
      end
      else
         pins <= pins_d;
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_busy_set;
      @(posedge clk_sys) disable iff (!rst_n) start_fall && !conv_done |=> busy;
   endproperty
   a_busy_set: assert property (p_busy_set) else $error("busy not raised"); // R14

   property p_busy_clr;
      @(posedge clk_sys) disable iff (!rst_n) conv_done |=> !busy;
   endproperty
   a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared"); // R14

   property p_format;
      @(posedge clk_sys) disable iff (!rst_n)
         conv_done && !err_cond |=> result_q[17] == ($past(conv_result[17]) ^ $past(cfg.fmt));
   endproperty
   a_format: assert property (p_format) else $error("format bit wrong"); // R5

   property p_master_stable;
      @(posedge clk_sys) disable iff (!rst_n)
         master && st_q == ST_SHIFT && $changed(pins.dout[`AROP_BIT_SCLK])
            |-> $stable(pins.dout[`AROP_BIT_SER_DATA]);
   endproperty
   a_master_stable: assert property (p_master_stable) else $error("data moved on clock edge"); // R6

   property p_sync;
      @(posedge clk_sys) disable iff (!rst_n)
         master && st_q == ST_SHIFT && $stable(cfg) |=> pins.dout[`AROP_BIT_SYNC] == !cfg.sync_inv;
   endproperty
   a_sync: assert property (p_sync) else $error("sync level wrong"); // R10 R11

   property p_rderr;
      @(posedge clk_sys) disable iff (!rst_n) err_cond |=> ##1 pins.dout[`AROP_BIT_RDERR] ##1 !err_q;
   endproperty
   a_rderr: assert property (p_rderr) else $error("read error pulse wrong"); // R12

   property p_high_bits;
      @(posedge clk_sys) disable iff (!rst_n) 1'b1 |-> (pins.oe[17:14] == 4'hF);
   endproperty
   a_high_bits: assert property (p_high_bits) else $error("bits 14-17 not driven"); // R13

   property p_enable;
      @(posedge clk_sys) disable iff (!rst_n) !en |=> (pins.oe[13:0] == 14'h0000);
   endproperty
   a_enable: assert property (p_enable) else $error("driver on without select"); // R18

   property p_frame_start;
      @(posedge clk_sys) disable iff (!rst_n) start_m |=> st_q == ST_SHIFT && cnt_q == 5'h00;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame did not start"); // R20
endmodule

/* File: tb/arop_host_model.sv */
// Host model: selects the port, clocks slave reads, captures master frames
`timescale 1ns/1ps
module arop_host_model (
   input  wire logic                    clk_sys,
   input  wire arop_pkg::arop_pins_t    pins,
   input  wire arop_pkg::arop_ser_cfg_t cfg,
   output logic                         cs_n,
   output logic                         rd_n,
   output logic                         sclk_in,
   output logic                         chain_data_in
);
   import arop_pkg::*;
   // ****************
   // Host side
   // ****************
   logic        sck_last;
   logic [17:0] mcap;
   logic [18:0] scap;
   int          nbits;
   int          nsync;
   int          nbad;
   initial
   begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      sclk_in = 1'b0;
      chain_data_in = 1'b1;
      scap = 19'h0;
   end
   task automatic clear();
      nbits = 0;
      nsync = 0;
      nbad = 0;
   endtask
   task automatic select(input logic off, input logic idle);
      sclk_in = idle;
      cs_n = off;
      rd_n = off;
      repeat (8) @(posedge clk_sys);
      #2;
   endtask
   // Link clock is unrelated to clk_sys; data sampled just before the next update edge
   task automatic slave_read(input int n, input logic inv);
      for (int i = 0; i < n; i++)
      begin
         sclk_in = !inv;
         #100;
         sclk_in = inv;
         #100;
         scap = {scap[17:0], pins.dout[10]};
      end
      @(posedge clk_sys);
      #2;
   endtask
   // Master frames: capture on the active edge, verify stability on the other
   always @(posedge clk_sys)
   begin
      sck_last <= pins.dout[11] ^ cfg.clk_inv;
      if ((pins.dout[11] ^ cfg.clk_inv) && !sck_last)
      begin
         mcap <= {mcap[16:0], pins.dout[10]};
         nbits <= nbits + 1;
         nsync <= nsync + ((pins.dout[12] === !cfg.sync_inv) ? 1 : 0);
      end
      if (!(pins.dout[11] ^ cfg.clk_inv) && sck_last && pins.dout[10] !== mcap[0])
         nbad <= nbad + 1;
   end
endmodule

/* File: tb/arop_port_bench.sv */
// Self-checking bench of the result output port
`timescale 1ns/1ps
`include "arop_params.svh"
module arop_port_bench;
   import arop_pkg::*;
   // ****************
   // Bench
   // ****************
   logic          clk_sys;
   logic          arst_n;
   logic [1:0]    mode;
   arop_ser_cfg_t cfg;
   logic          cs_n;
   logic          rd_n;
   logic          conversion_start_n;
   logic          sclk_in;
   logic          chain_data_in;
   logic          conv_done;
   logic [17:0]   conv_result;
   arop_pins_t    pins;
   logic          busy;
   logic [17:0]   prev;
   logic          err_seen;
   int            fails;
   int            compares;
   arop_port dut (.clk_sys(clk_sys), .arst_n(arst_n), .mode(mode), .cfg(cfg), .cs_n(cs_n), .rd_n(rd_n),
      .conversion_start_n(conversion_start_n), .sclk_in(sclk_in), .chain_data_in(chain_data_in),
      .conv_done(conv_done), .conv_result(conv_result), .pins(pins), .busy(busy));
   arop_host_model host (.clk_sys(clk_sys), .pins(pins), .cfg(cfg), .cs_n(cs_n), .rd_n(rd_n),
      .sclk_in(sclk_in), .chain_data_in(chain_data_in));
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
      if (mode == 2'h3 && cfg.clk_src && pins.dout[13] === 1'b1)
         err_seen <= 1'b1;
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   task automatic check18(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic convert(input logic [17:0] res, input int gap);
      conversion_start_n = 1'b0;
      cycles(8);
      check1(busy, 1'b1);
      conversion_start_n = 1'b1;
      cycles(gap);
      conv_result = res;
      conv_done = 1'b1;
      cycles(1);
      conv_done = 1'b0;
      cycles(2);
      check1(busy, 1'b0);
      prev = res;
   endtask
   task automatic test_parallel();
      logic [17:0] r;
      host.select(1'b0, 1'b0);
      for (int m = 0; m < 3; m++)
      begin
         mode = m[1:0];
         cfg.fmt = m[0];
         r = 18'h2A5B4 ^ {16'h0, m[1:0]};
         convert(r, 4);
         check18(pins.dout, r ^ {m[0], 17'h0});
         check18(pins.oe, 18'h3FFFF);
      end
      host.select(1'b1, 1'b0);
      check18(pins.oe, 18'h3C000);
      $display("test parallel done");
   endtask
   task automatic test_master();
      logic [17:0] r;
      logic [17:0] exp;
      mode = `AROP_MODE_SERIAL;
      host.select(1'b0, 1'b0);
      for (int v = 0; v < 4; v++)
      begin
         r = 18'h1C3A5 ^ {14'h0, v[1:0], 2'h0};
         exp = v[1] ? prev : r;
         cfg = '{clk_src:1'b0, clk_inv:v[0], sync_inv:v[0], rd_timing:v[1], fmt:1'b0};
         cycles(4);
         host.clear();
         convert(r, v[1] ? 200 : 4);
         for (int i = 0; i < 200 && host.nbits < 18; i++)
            cycles(1);
         cycles(8);
         check18(host.mcap, exp);
         check1(host.nbits == 18 && host.nsync == 18 && host.nbad == 0, 1'b1);
         check18(pins.oe, 18'h3DC00);
      end
      $display("test master done");
   endtask
   task automatic test_slave();
      err_seen = 1'b0;
      for (int v = 0; v < 2; v++)
      begin
         cfg = '{clk_src:1'b1, clk_inv:v[0], sync_inv:1'b0, rd_timing:1'b0, fmt:1'b0};
         host.select(1'b1, v[0]);
         host.select(1'b0, v[0]);
         convert(18'h2A5B4, 4);
         host.slave_read(19, v[0]);
         check18(host.scap[18:1], 18'h2A5B4);
         check1(host.scap[0], 1'b1);
         check18(pins.oe, 18'h3E400);
      end
      check1(err_seen, 1'b0);
      host.select(1'b1, 1'b0);
      host.select(1'b0, 1'b0);
      host.slave_read(5, 1'b0);
      convert(18'h0F0F0, 4);
      check1(err_seen, 1'b1);
      check18({pins.dout[17:14], 14'h0}, {4'hA, 14'h0});
      host.select(1'b1, 1'b0);
      $display("test slave done");
   endtask
   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Whole run is about 1,200 cycles; this limit leaves ample margin
   initial
   begin
      #1000000;
      fails++;
      report_and_stop();
   end
   initial
   begin
      arst_n = 1'b0;
      mode = 2'h0;
      cfg = '0;
      conversion_start_n = 1'b1;
      conv_done = 1'b0;
      conv_result = 18'h0;
      prev = 18'h0;
      err_seen = 1'b0;
      fails = 0;
      compares = 0;
      repeat (12) @(posedge clk_sys);
      #2;
      arst_n = 1'b1;
      cycles(10);
      test_parallel();
      test_master();
      test_slave();
      report_and_stop();
   end
endmodule
